// *** hw/audio_port_clock_source_select.sv ***
// Register-programmed clock source selection and checking for three audio
// ports. Assumes the analogue muxes and loops follow the select outputs and
// that software sets the sync marks only for externally synchronised clocks.
module audio_port_clock_source_select
    import clk_sel_pkg::*;
#(
    parameter int PORTS = 3
)(
    input  wire logic                      i_clk,
    input  wire logic                      i_reset,
    input  wire logic                      i_ce,
    input  wire clk_sel_pkg::reg_req_s     i_req,
    output logic [clk_sel_pkg::DATA_W-1:0] o_rdata,
    output logic [3:0]                     o_main_domain_source_sel,
    output logic [3:0]                     o_second_domain_source_sel,
    output logic [3:0]                     o_loop_one_reference_sel,
    output logic [3:0]                     o_loop_two_reference_sel,
    output logic [PORTS-1:0]               o_port_drive,
    output logic [PORTS-1:0]               o_port_domain,
    output logic [PORTS-1:0]               o_cfg_err,
    output logic                           o_irq
);
    import clk_sel_pkg::*;

    initial
    begin
        if (PORTS < 1 || PORTS > 3)
            $error("PORTS must be 1 to 3");
    end

    // ==========================================================
    // Helper functions
    // Reference codes that name a real clock
    function automatic logic ref_valid(input logic [3:0] r);
        return r == REF_MASTER_ONE || r == REF_MASTER_TWO || r == REF_LINK
            || (r >= REF_BCLK0 && r <= REF_BCLK0 + 4'h2)
            || (r >= REF_FCLK0 && r <= REF_FCLK0 + 4'h2);
    endfunction : ref_valid

    // Is a loop reference acceptable for port p
    function automatic logic ref_ok(input logic m, input logic [3:0] r,
                                    input logic [15:0] mk, input logic [1:0] p);
        logic own;
        own = r == REF_BCLK0 + {2'b00, p} || r == REF_FCLK0 + {2'b00, p};
        // Master cannot lock to clocks it drives itself
        if (m)
            return ref_valid(r) && !own;
        case (r)
            REF_MASTER_ONE: return mk[p];
            REF_MASTER_TWO: return mk[MARK_MASTER_TWO_LSB + p];
            REF_LINK:       return mk[MARK_LINK_LSB + p];
            default:        return own;
        endcase
    endfunction : ref_ok

    // Is a domain source acceptable for port p
    function automatic logic src_ok(input logic m, input logic [3:0] s,
                                    input logic [3:0] r1, input logic [3:0] r2,
                                    input logic [15:0] mk, input logic [1:0] p);
        // Both master clocks and both loops treated alike
        case (s)
            SRC_MASTER_ONE: return m || mk[p];
            SRC_MASTER_TWO: return m || mk[MARK_MASTER_TWO_LSB + p];
            SRC_LOOP1:      return ref_ok(m, r1, mk, p);
            SRC_LOOP2:      return ref_ok(m, r2, mk, p);
            default:        return 1'b0;
        endcase
    endfunction : src_ok

    // ==========================================================
    // Registers
    logic [DATA_W-1:0] mode_q;
    logic [DATA_W-1:0] rate_q;
    logic [DATA_W-1:0] dsrc_q;
    logic [DATA_W-1:0] lref_q;
    logic [DATA_W-1:0] mark_q;
    logic [DATA_W-1:0] freq_q;
    logic [DATA_W-1:0] irq_sts_q;
    logic [DATA_W-1:0] irq_sts_d;
    logic [DATA_W-1:0] irq_mask_q;
    logic [DATA_W-1:0] rdata_q;
    logic [PORTS-1:0]  err_d;
    logic [PORTS-1:0]  err_q;
    logic [PORTS-1:0]  ratio_d;
    logic [PORTS-1:0]  ratio_q;
    logic [PORTS-1:0]  dom_d;
    logic [PORTS-1:0]  drive_q;
    logic [PORTS-1:0]  dom_q;
    logic              irq_q;
    logic              wr;
    logic              rd;

    assign wr = i_ce && i_req.we;
    assign rd = i_ce && i_req.re;

    // Software writable configuration
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            mode_q     <= RST_PORT_MODE;
            rate_q     <= RST_PORT_RATE;
            dsrc_q     <= RST_DOMAIN_SRC;
            lref_q     <= RST_LOOP_REF;
            mark_q     <= RST_SYNC_MARK;
            freq_q     <= RST_FREQ;
            irq_mask_q <= RST_IRQ_MASK;
        end
        else if (wr)
        begin
            case (i_req.addr)
                OFS_PORT_MODE:  mode_q     <= i_req.wdata;
                OFS_PORT_RATE:  rate_q     <= i_req.wdata;
                OFS_DOMAIN_SRC: dsrc_q     <= i_req.wdata;
                OFS_LOOP_REF:   lref_q     <= i_req.wdata;
                OFS_SYNC_MARK:  mark_q     <= i_req.wdata;
                OFS_FREQ:       freq_q     <= i_req.wdata;
                OFS_IRQ_MASK:   irq_mask_q <= i_req.wdata;
                default:        ;
            endcase
        end
    end

    // ==========================================================
    // Per-port checking
    // Domain choice, source check and ratio check for each port
    always_comb
    begin
        logic [3:0] s;
        logic [2:0] f;
        s = 4'h0;
        f = 3'h0;
        for (int p = 0; p < PORTS; p++)
        begin
            dom_d[p] = rate_q[4*p+3 -: 4] >= RATE_SECOND;
            s = dom_d[p] ? dsrc_q[SECOND_SRC_LSB +: 4] : dsrc_q[3:0];
            f = dom_d[p] ? freq_q[SECOND_FRQ_LSB +: 3] : freq_q[2:0];
            // Unsynchronised slave source is flagged, master is checked too
            err_d[p] = mode_q[MODE_EN_LSB + p]
                && !src_ok(mode_q[p], s, lref_q[3:0],
                           lref_q[LOOP2_REF_LSB +: 4], mark_q, 2'(p));
            ratio_d[p] = mode_q[MODE_EN_LSB + p]
                && (f < FREQ_MIN || f > FREQ_MAX);
        end
    end

    // Port drive and status flops
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            drive_q <= '0;
            dom_q   <= '0;
            err_q   <= '0;
            ratio_q <= '0;
        end
        else if (i_ce)
        begin
            // Enabled master ports drive their bit and frame clocks
            drive_q <= mode_q[PORTS-1:0] & mode_q[MODE_EN_LSB +: PORTS];
            dom_q   <= dom_d;
            err_q   <= err_d;
            ratio_q <= ratio_d;
        end
    end

    // ==========================================================
    // Interrupts
    // New errors set sticky bits; a read clears, but a same-cycle event wins
    always_comb
    begin
        irq_sts_d = irq_sts_q;
        if (rd && i_req.addr == OFS_IRQ_STS)
            irq_sts_d = '0;
        irq_sts_d[PORTS-1:0] = irq_sts_d[PORTS-1:0] | (err_d & ~err_q);
        irq_sts_d[RATIO_ERR_LSB +: PORTS] = irq_sts_d[RATIO_ERR_LSB +: PORTS]
            | (ratio_d & ~ratio_q);
    end

    // Sticky status and level output; output lags status by one cycle
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            irq_sts_q <= '0;
            irq_q     <= 1'b0;
        end
        else if (i_ce)
        begin
            irq_sts_q <= irq_sts_d;
            irq_q     <= |(irq_sts_q & irq_mask_q);
        end
    end

    // ==========================================================
    // Read port
    // Data stand one cycle after the strobe, zero after other enabled cycles; held while enable is low
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            rdata_q <= '0;
        else if (i_ce)
        begin
            rdata_q <= '0;
            if (rd)
            begin
                case (i_req.addr)
                    OFS_PORT_MODE:  rdata_q <= mode_q;
                    OFS_PORT_RATE:  rdata_q <= rate_q;
                    OFS_DOMAIN_SRC: rdata_q <= dsrc_q;
                    OFS_LOOP_REF:   rdata_q <= lref_q;
                    OFS_SYNC_MARK:  rdata_q <= mark_q;
                    OFS_FREQ:       rdata_q <= freq_q;
                    OFS_STATUS:     rdata_q <= 16'({ratio_q, 1'b0, err_q});
                    OFS_IRQ_STS:    rdata_q <= irq_sts_q;
                    OFS_IRQ_MASK:   rdata_q <= irq_mask_q;
                    default:        rdata_q <= '0;
                endcase
            end
        end
    end

    assign o_rdata                    = rdata_q;
    assign o_main_domain_source_sel   = dsrc_q[3:0];
    assign o_second_domain_source_sel = dsrc_q[SECOND_SRC_LSB +: 4];
    assign o_loop_one_reference_sel   = lref_q[3:0];
    assign o_loop_two_reference_sel   = lref_q[LOOP2_REF_LSB +: 4];
    assign o_port_drive               = drive_q;
    assign o_port_domain              = dom_q;
    assign o_cfg_err                  = err_q;
    assign o_irq                      = irq_q;

    // ==========================================================
    // Checks
    chk_master_drive_write: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (wr && i_req.addr == OFS_PORT_MODE) ##1 i_ce
        |=> o_port_drive[0] == ($past(i_req.wdata[0], 2)
                                && $past(i_req.wdata[MODE_EN_LSB], 2)))
        else $error("master drive does not follow mode write");

    chk_rate_domain: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && rate_q[3:0] >= RATE_SECOND) |=> o_port_domain[0])
        else $error("high rate code did not select second domain");

    chk_slave_unsynced: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && mode_q[MODE_EN_LSB] && !mode_q[0] && rate_q[3:0] < RATE_SECOND
         && dsrc_q[3:0] == SRC_MASTER_ONE && !mark_q[0]) |=> o_cfg_err[0])
        else $error("unsynchronised slave source not flagged");

    chk_slave_bclk_ok: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && mode_q[MODE_EN_LSB] && !mode_q[0] && rate_q[3:0] < RATE_SECOND
         && dsrc_q[3:0] == SRC_LOOP2 && lref_q[7:4] == REF_BCLK0) |=> !o_cfg_err[0])
        else $error("bit clock loop reference flagged");

    chk_master_mclk_ok: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && mode_q[MODE_EN_LSB] && mode_q[0] && rate_q[3:0] < RATE_SECOND
         && dsrc_q[3:0] == SRC_MASTER_TWO) |=> !o_cfg_err[0])
        else $error("master clock source flagged for master port");

    chk_ratio_bad: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && mode_q[MODE_EN_LSB] && rate_q[3:0] < RATE_SECOND
         && freq_q[2:0] == 3'h0 && !ratio_q[0]) |=> irq_sts_q[RATIO_ERR_LSB])
        else $error("ratio error not recorded");

    chk_read_clears: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (rd && i_req.addr == OFS_IRQ_STS && err_d == err_q && ratio_d == ratio_q)
        |=> o_rdata == $past(irq_sts_q) && irq_sts_q == '0)
        else $error("status read did not return and clear");

    chk_set_wins: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (rd && i_req.addr == OFS_IRQ_STS && err_d[0] && !err_q[0])
        |=> irq_sts_q[0])
        else $error("event lost during status clear");

    chk_irq_level: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && |(irq_sts_q & irq_mask_q)) |=> o_irq)
        else $error("interrupt not raised for unmasked status");

    // No unmasked status means a quiet interrupt line
    chk_irq_quiet: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && !(|(irq_sts_q & irq_mask_q))) |=> !o_irq)
        else $error("interrupt raised with nothing unmasked");

    // Read data rest at zero after an enabled cycle without a read
    chk_rdata_idle: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && !rd) |=> o_rdata == '0)
        else $error("read data shown without a read");

    // Clock enable low freezes configuration, status and outputs
    chk_ce_freeze: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !i_ce |=> $stable(mode_q) && $stable(irq_sts_q) && $stable(o_port_drive))
        else $error("state moved while clock enable was low");

    // A port with its enable low never drives and never reports
    chk_disabled_quiet: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && !mode_q[MODE_EN_LSB]) |=> !o_port_drive[0] && !o_cfg_err[0])
        else $error("disabled port drives or reports an error");

    // An enabled master always owns its bit and frame clocks
    chk_master_drives: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && mode_q[0] && mode_q[MODE_EN_LSB]) |=> o_port_drive[0])
        else $error("enabled master port not driving its clocks");

    // Low rate codes keep the port on the main domain
    chk_rate_main: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && rate_q[3:0] < RATE_SECOND) |=> !o_port_domain[0])
        else $error("low rate code did not select main domain");

    // A master locking a loop to its own bit clock would chase itself
    chk_master_own_ref: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && mode_q[MODE_EN_LSB + 1] && mode_q[1] && rate_q[7:4] < RATE_SECOND
         && dsrc_q[3:0] == SRC_LOOP1 && lref_q[3:0] == REF_BCLK0 + 4'h1) |=> o_cfg_err[1])
        else $error("master loop locked to own bit clock not flagged");

    // Link reference for a slave is fine once marked as synchronised
    chk_slave_link_ok: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (i_ce && mode_q[MODE_EN_LSB] && !mode_q[0] && rate_q[3:0] < RATE_SECOND
         && dsrc_q[3:0] == SRC_LOOP2 && lref_q[7:4] == REF_LINK && mark_q[MARK_LINK_LSB])
        |=> !o_cfg_err[0])
        else $error("marked link reference flagged for slave port");
endmodule : audio_port_clock_source_select

// *** pkg/clk_sel_pkg.sv ***
// Constants and carriers for the audio port clock source selection block.
// Assumes one 100 MHz control clock; the clock muxes and loops sit outside.
// Overview of operation
// - Each port works as master or slave
// - Master ports drive bit and frame clocks
// - Master domain from either master clock, maybe looped
// - Master may lock loop to port or link
// - Slave domain must track incoming port clocks
// - Slave usually locks loop to bit clock
// - Rate code 8 upward selects second domain
// - Loop reference: master clocks, port clocks, link
// - Domain frequency must suit frame rate
// - Both master clocks and loops are interchangeable
package clk_sel_pkg;
    // ==========================================================
    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } reg_req_s;
    // ==========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_PORT_MODE  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_PORT_RATE  = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_DOMAIN_SRC = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_LOOP_REF   = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_SYNC_MARK  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_FREQ       = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STS    = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 4'h8;
    // ==========================================================
    // Field positions
    localparam int MODE_EN_LSB         = 4;
    localparam int SECOND_SRC_LSB      = 4;
    localparam int LOOP2_REF_LSB       = 4;
    localparam int MARK_MASTER_TWO_LSB = 4;
    localparam int MARK_LINK_LSB       = 8;
    localparam int SECOND_FRQ_LSB      = 4;
    localparam int RATIO_ERR_LSB       = 4;
    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] RST_PORT_MODE  = 16'h0000;
    localparam logic [DATA_W-1:0] RST_PORT_RATE  = 16'h0000;
    localparam logic [DATA_W-1:0] RST_DOMAIN_SRC = 16'h0000;
    localparam logic [DATA_W-1:0] RST_LOOP_REF   = 16'h0000;
    localparam logic [DATA_W-1:0] RST_SYNC_MARK  = 16'h0000;
    localparam logic [DATA_W-1:0] RST_FREQ       = 16'h0011;
    localparam logic [DATA_W-1:0] RST_IRQ_MASK   = 16'h0000;
    // ==========================================================
    // Source and reference encodings, rate threshold and frequency limits
    localparam logic [3:0] SRC_MASTER_ONE = 4'h0;
    localparam logic [3:0] SRC_MASTER_TWO = 4'h1;
    localparam logic [3:0] SRC_LOOP1      = 4'h4;
    localparam logic [3:0] SRC_LOOP2      = 4'h5;
    localparam logic [3:0] REF_MASTER_ONE = 4'h0;
    localparam logic [3:0] REF_MASTER_TWO = 4'h1;
    localparam logic [3:0] REF_BCLK0      = 4'h8;
    localparam logic [3:0] REF_FCLK0      = 4'hc;
    localparam logic [3:0] REF_LINK       = 4'hf;
    localparam logic [3:0] RATE_SECOND    = 4'h8;
    localparam logic [2:0] FREQ_MIN       = 3'h1;
    localparam logic [2:0] FREQ_MAX       = 3'h6;
endpackage : clk_sel_pkg

// *** sim/audio_far_end.sv ***
// Behavioural model of the external audio devices on the three ports.
// Assumes the block's drive outputs show which side owns the port clocks.
module audio_far_end
(
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic [2:0] i_port_drive,
    output logic      [2:0] o_far_bclk,
    output logic      [2:0] o_far_drives
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] root_q;
    // ==========================================================
    // One root divider feeds every port, so far clocks share one root
    always_ff @(posedge i_clk)
    begin
        root_q <= i_reset ? 2'h0 : root_q + 2'h1;
    end
    // A slave port gets clocks from here; a released line toggles, never holds
    always_comb
    begin
        o_far_drives = ~i_port_drive;
        for (int p = 0; p < 3; p++)
            o_far_bclk[p] = o_far_drives[p] ? root_q[1] : root_q[0];
    end
endmodule : audio_far_end

// *** sim/audio_port_clock_source_select_tb.sv ***
// Self-checking bench for the audio port clock source selection block.
// Assumes the register map and error rules in the clk_sel_pkg constants.
module audio_port_clock_source_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import clk_sel_pkg::*;
    typedef struct packed {
        logic [15:0] mode, rate, src, lref, mark;
        logic [2:0]  drive, domain, err;
    } row_s;
    logic        i_clk, i_reset, i_ce;
    reg_req_s    i_req;
    logic [15:0] o_rdata;
    logic [3:0]  main_sel, second_sel, ref_one, ref_two;
    logic [2:0]  drive, domain, cfg_err, far_bclk, far_drives;
    logic        o_irq;
    int          fails, total_checks, cycles;
    row_s        rows [17];
    audio_port_clock_source_select i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
        .i_req(i_req), .o_rdata(o_rdata), .o_main_domain_source_sel(main_sel),
        .o_second_domain_source_sel(second_sel), .o_loop_one_reference_sel(ref_one),
        .o_loop_two_reference_sel(ref_two), .o_port_drive(drive), .o_port_domain(domain),
        .o_cfg_err(cfg_err), .o_irq(o_irq));
    audio_far_end i_far (.i_clk(i_clk), .i_reset(i_reset), .i_port_drive(drive),
        .o_far_bclk(far_bclk), .o_far_drives(far_drives));
    // ==========================================================
    // Clock and cycle ceiling; the whole run needs well under a thousand cycles
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fails++;
            complete_run();
        end
    end
    // ==========================================================
    // Tasks
    task automatic check_value(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check_value
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge i_clk);
        i_req.we <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe, so sample just then
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_req <= '{addr: a, wdata: 16'h0, we: 1'b0, re: 1'b1};
        @(posedge i_clk);
        i_req.re <= 1'b0;
        #1 check_value(name, exp, o_rdata);
    endtask : rd_chk
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : settle
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    // ==========================================================
    // Main sequence: table rows first, then reset and awkward cases
    initial
    begin
        // Mode, rate, source, loop ref, sync mark, then drive, domain, error
        rows = '{
            '{16'h0077, 16'h0, 16'h0000, 16'h0000, 16'h0000, 3'h7, 3'h0, 3'h0},
            '{16'h0077, 16'h0, 16'h0001, 16'h0000, 16'h0000, 3'h7, 3'h0, 3'h0},
            '{16'h0077, 16'h0, 16'h0004, 16'h0000, 16'h0000, 3'h7, 3'h0, 3'h0},
            '{16'h0077, 16'h0, 16'h0005, 16'h0010, 16'h0000, 3'h7, 3'h0, 3'h0},
            '{16'h0077, 16'h0, 16'h0004, 16'h0009, 16'h0000, 3'h7, 3'h0, 3'h2},
            '{16'h0077, 16'h0, 16'h0004, 16'h000f, 16'h0000, 3'h7, 3'h0, 3'h0},
            '{16'h0077, 16'h0, 16'h0004, 16'h000d, 16'h0000, 3'h7, 3'h0, 3'h2},
            '{16'h0070, 16'h0, 16'h0004, 16'h0008, 16'h0000, 3'h0, 3'h0, 3'h6},
            '{16'h0070, 16'h0, 16'h0000, 16'h0000, 16'h0000, 3'h0, 3'h0, 3'h7},
            '{16'h0070, 16'h0, 16'h0000, 16'h0000, 16'h0007, 3'h0, 3'h0, 3'h0},
            '{16'h0070, 16'h0, 16'h0005, 16'h00f0, 16'h0500, 3'h0, 3'h0, 3'h2},
            '{16'h0077, 16'h0888, 16'h0020, 16'h0, 16'h0000, 3'h7, 3'h7, 3'h7},
            '{16'h0077, 16'h0807, 16'h0070, 16'h0, 16'h0000, 3'h7, 3'h4, 3'h4},
            '{16'h0010, 16'h0, 16'h0000, 16'h0000, 16'h0000, 3'h0, 3'h0, 3'h1},
            '{16'h0070, 16'h0, 16'h0004, 16'h0001, 16'h0020, 3'h0, 3'h0, 3'h5},
            '{16'h0070, 16'h0, 16'h0004, 16'h000e, 16'h0000, 3'h0, 3'h0, 3'h3},
            '{16'h0070, 16'h0, 16'h0005, 16'h0080, 16'h0000, 3'h0, 3'h0, 3'h6}
        };
        i_reset = 1'b1;
        i_ce = 1'b1;
        i_req = '0;
        fails = 0;
        total_checks = 0;
        cycles = 0;
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        foreach (rows[i])
        begin
            wr(OFS_PORT_MODE, rows[i].mode);
            wr(OFS_PORT_RATE, rows[i].rate);
            wr(OFS_DOMAIN_SRC, rows[i].src);
            wr(OFS_LOOP_REF, rows[i].lref);
            wr(OFS_SYNC_MARK, rows[i].mark);
            settle(2);
            check_value("drive", 16'(rows[i].drive), 16'(drive));
            check_value("domain", 16'(rows[i].domain), 16'(domain));
            check_value("cfg_err", 16'(rows[i].err), 16'(cfg_err));
            check_value("main_src", 16'(rows[i].src[3:0]), 16'(main_sel));
            check_value("second_src", 16'(rows[i].src[7:4]), 16'(second_sel));
            check_value("ref_one", 16'(rows[i].lref[3:0]), 16'(ref_one));
            check_value("ref_two", 16'(rows[i].lref[7:4]), 16'(ref_two));
            check_value("far_drives", {13'h0, ~rows[i].drive}, 16'(far_drives));
            $display("Row %0d done", i);
        end
        // Mid-run reset restores every register and output
        @(posedge i_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        #1;
        check_value("drive_rst", 16'h0, 16'(drive));
        check_value("err_rst", 16'h0, 16'(cfg_err));
        check_value("sel_rst", 16'h0, {main_sel, second_sel, ref_one, ref_two});
        check_value("irq_rst", 16'h0, 16'({domain, o_irq}));
        rd_chk("freq_rst", OFS_FREQ, RST_FREQ);
        rd_chk("mode_rst", OFS_PORT_MODE, RST_PORT_MODE);
        $display("Reset test done");
        // Unmapped and read-only places, and writes with the enable low
        wr(4'h9, 16'hffff);
        rd_chk("unmapped", 4'h9, 16'h0);
        wr(OFS_STATUS, 16'hffff);
        rd_chk("status_ro", OFS_STATUS, 16'h0);
        @(posedge i_clk);
        i_ce <= 1'b0;
        wr(OFS_PORT_MODE, 16'h0077);
        i_ce <= 1'b1;
        rd_chk("ce_low", OFS_PORT_MODE, 16'h0);
        $display("Access test done");
        // Frequency codes at both ends of the legal range
        wr(OFS_PORT_MODE, 16'h0077);
        wr(OFS_FREQ, 16'h0010);
        settle(3);
        rd_chk("ratio_bad", OFS_STATUS, 16'h0070);
        wr(OFS_FREQ, 16'h0016);
        settle(3);
        rd_chk("ratio_ok", OFS_STATUS, 16'h0000);
        rd_chk("irq_sts", OFS_IRQ_STS, 16'h0070);
        rd_chk("irq_clr", OFS_IRQ_STS, 16'h0000);
        wr(OFS_FREQ, 16'h0017);
        settle(3);
        rd_chk("ratio_top", OFS_STATUS, 16'h0070);
        wr(OFS_FREQ, 16'h0011);
        settle(3);
        rd_chk("irq_top", OFS_IRQ_STS, 16'h0070);
        $display("Ratio test done");
        // Masked event stays quiet until unmasked; a status read drops the line
        wr(OFS_PORT_MODE, 16'h0076);
        settle(4);
        check_value("irq_masked", 16'h0, 16'(o_irq));
        wr(OFS_IRQ_MASK, 16'h0001);
        settle(2);
        check_value("irq_on", 16'h1, 16'(o_irq));
        rd_chk("irq_sts", OFS_IRQ_STS, 16'h0001);
        settle(2);
        check_value("irq_off", 16'h0, 16'(o_irq));
        // A new error in the cycle of a status read survives the clear
        wr(OFS_PORT_MODE, 16'h0000);
        settle(2);
        @(posedge i_clk);
        i_req <= '{addr: OFS_PORT_MODE, wdata: 16'h0010, we: 1'b1, re: 1'b0};
        @(posedge i_clk);
        i_req <= '{addr: OFS_IRQ_STS, wdata: 16'h0000, we: 1'b0, re: 1'b1};
        @(posedge i_clk);
        i_req.re <= 1'b0;
        #1 check_value("sts_empty", 16'h0, o_rdata);
        rd_chk("set_wins", OFS_IRQ_STS, 16'h0001);
        $display("Interrupt test done");
        complete_run();
    end
endmodule : audio_port_clock_source_select_tb
